// >>> design/wake_irq_pkg.sv
// package: constants, modes and carriers for the wake input and interrupt pulse block
package wake_irq_pkg;

  localparam int CLK_MHZ = 100;
  // wake pin filter, typical 16 us
  localparam int FILTER_US = 16;
  localparam int FILTER_CYCLES = FILTER_US * CLK_MHZ;
  // interrupt pulse width and minimum high gap, typical 100 us each
  localparam int IRQ_PULSE_US = 100;
  localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_US * CLK_MHZ;
  localparam int IRQ_GAP_US = 100;
  localparam int IRQ_GAP_CYCLES = IRQ_GAP_US * CLK_MHZ;
  localparam int CNT_W = 14;

  // register map, word index on the plain port
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_BIAS = 4'h1;
  localparam logic [3:0] ADDR_LEVEL = 4'h2;
  localparam logic [3:0] ADDR_STAT1 = 4'h3;
  localparam logic [3:0] ADDR_STAT2 = 4'h4;
  localparam logic [3:0] ADDR_SRCEN = 4'h5;

  // control register fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CYCLIC_BIT = 1;
  localparam int CTRL_MODSEL_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] BIAS_RESET = 2'h0;
  localparam logic [7:0] SRCEN_RESET = 8'h00;
  localparam int PIN_WAKE_BIT = 0;

  // bias select encoding
  localparam logic [1:0] BIAS_NONE = 2'h0;
  localparam logic [1:0] BIAS_DOWN = 2'h1;
  localparam logic [1:0] BIAS_UP = 2'h2;
  localparam logic [1:0] BIAS_AUTO = 2'h3;

  // chip modes as seen by this block
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h1;
  localparam logic [2:0] MODE_SLEEP = 3'h2;
  localparam logic [2:0] MODE_FAILSAFE = 3'h3;
  localparam logic [2:0] MODE_RESTART = 3'h4;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic pull_up;
    logic pull_down;
  } bias_drive_t;

endpackage

// >>> design/wake_irq.sv
// wake input filter, wake status flags and interrupt pulse generator
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module wake_irq (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wake_pin,
  input wire logic [2:0] chip_mode,
  input wire logic stop_entry,
  input wire logic cyclic_window,
  input wire logic buck_auto_pwm,
  input wire logic [7:0] other_wake_events,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq_n_out,
  output logic wake_request,
  output logic restart_request,
  output logic buck_pwm_select,
  output logic pull_up_en,
  output logic pull_down_en
);

  // --------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  wake_irq_pkg::reg_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  function automatic logic hit(input wake_irq_pkg::reg_req_t r, input logic [3:0] a);
    hit = r.addr == a;
  endfunction

  // --------------------------------------------------------------
  // registers written by software
  // --------------------------------------------------------------
  logic [7:0] ctrl;
  logic [1:0] bias_sel;
  logic [7:0] src_en;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= wake_irq_pkg::CTRL_RESET;
      bias_sel <= wake_irq_pkg::BIAS_RESET;
      src_en <= wake_irq_pkg::SRCEN_RESET;
    end else if (req.wr) begin
      if (hit(req, wake_irq_pkg::ADDR_CTRL)) ctrl <= req.wdata;
      if (hit(req, wake_irq_pkg::ADDR_BIAS)) bias_sel <= req.wdata[1:0];
      if (hit(req, wake_irq_pkg::ADDR_SRCEN)) src_en <= req.wdata;
    end
  end

  logic wake_en;
  logic cyclic_mode;
  logic mod_sel;
  assign wake_en = ctrl[wake_irq_pkg::CTRL_ENABLE_BIT];
  assign cyclic_mode = ctrl[wake_irq_pkg::CTRL_CYCLIC_BIT];
  assign mod_sel = ctrl[wake_irq_pkg::CTRL_MODSEL_BIT];

  // --------------------------------------------------------------
  // pin synchroniser and filter
  // --------------------------------------------------------------
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= wake_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  logic raw_level;
  assign raw_level = s3;
  logic pin_agree;
  assign pin_agree = s2 == s3;

  // sensing is active always (static) or only inside cyclic windows
  logic sense_on;
  assign sense_on = !cyclic_mode || cyclic_window;

  logic filt_level;
  logic filt_valid;
  logic [wake_irq_pkg::CNT_W-1:0] filt_cnt;
  logic filt_edge;
  // the first level taken after reset is a baseline, so a pin idling high fakes no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_level <= 1'b0;
      filt_valid <= 1'b0;
      filt_cnt <= '0;
      filt_edge <= 1'b0;
    end else begin
      filt_edge <= 1'b0;
      // a glitch shorter than the filter restarts the count
      if (!pin_agree || (filt_valid && raw_level == filt_level) || !sense_on) begin
        filt_cnt <= '0;
      end else if (filt_cnt == wake_irq_pkg::CNT_W'(wake_irq_pkg::FILTER_CYCLES - 1)) begin
        filt_cnt <= '0;
        filt_level <= raw_level;
        filt_valid <= 1'b1;
        filt_edge <= filt_valid;
      end else begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end
  end

  logic mode_irq;
  assign mode_irq = chip_mode == wake_irq_pkg::MODE_NORMAL ||
                    chip_mode == wake_irq_pkg::MODE_STOP;
  logic in_stop;
  assign in_stop = chip_mode == wake_irq_pkg::MODE_STOP;

  // --------------------------------------------------------------
  // wake actions and status flags
  // --------------------------------------------------------------
  logic pin_wake;
  assign pin_wake = filt_edge && (wake_en || chip_mode == wake_irq_pkg::MODE_FAILSAFE);

  logic irq_fall;
  logic [7:0] pend1;
  logic [7:0] pend2;
  logic [7:0] stat1;
  logic [7:0] stat2;
  logic [7:0] ev1;
  assign ev1 = pin_wake ? 8'h01 : 8'h00;

  // events collect in pending bits; they post to status at the pulse's falling edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend1 <= 8'h00;
      pend2 <= 8'h00;
    end else if (irq_fall) begin
      pend1 <= ev1;
      pend2 <= other_wake_events;
    end else begin
      pend1 <= pend1 | ev1;
      pend2 <= pend2 | other_wake_events;
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat1 <= 8'h00;
      stat2 <= 8'h00;
    end else begin
      stat1 <= (stat1 & ~((req.wr && hit(req, wake_irq_pkg::ADDR_STAT1)) ? req.wdata : 8'h00))
               | (irq_fall ? pend1 : 8'h00);
      stat2 <= (stat2 & ~((req.wr && hit(req, wake_irq_pkg::ADDR_STAT2)) ? req.wdata : 8'h00))
               | (irq_fall ? pend2 : 8'h00);
    end
  end

  // --------------------------------------------------------------
  // interrupt causes
  // --------------------------------------------------------------
  logic pwm_prev;
  logic pwm_armed;
  logic irq_req;
  logic irq_event;
  // the first cycle after reset only loads the history, so a level already high is no edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_prev <= 1'b0;
      pwm_armed <= 1'b0;
    end else begin
      pwm_prev <= buck_auto_pwm;
      pwm_armed <= 1'b1;
    end
  end
  // only events count: enabled wake events, stop entry with flags set, a buck PWM rise in stop; level status is never a cause
  assign irq_event = mode_irq && (
      (pin_wake && wake_en) ||
      |(other_wake_events & src_en) ||
      (stop_entry && (|stat1 || |stat2)) ||
      (in_stop && pwm_armed && buck_auto_pwm && !pwm_prev));

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_GAP = 3'b100
  } irq_state_t;
  irq_state_t st;
  logic [wake_irq_pkg::CNT_W-1:0] irq_cnt;

  // a request that arrives during a pulse or gap waits for the next free slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_req <= 1'b0;
    else if (irq_event) irq_req <= 1'b1;
    else if (st == ST_IDLE) irq_req <= 1'b0;
  end

  assign irq_fall = st == ST_IDLE && irq_req;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_IDLE;
      irq_cnt <= '0;
      irq_n_out <= 1'b1;
    end else begin
      case (st)
        ST_IDLE: begin
          if (irq_req) begin
            st <= ST_LOW;
            irq_cnt <= '0;
            irq_n_out <= 1'b0;
          end
        end
        ST_LOW: begin
          if (irq_cnt == wake_irq_pkg::CNT_W'(wake_irq_pkg::IRQ_PULSE_CYCLES - 1)) begin
            st <= ST_GAP;
            irq_cnt <= '0;
            irq_n_out <= 1'b1;
          end else begin
            irq_cnt <= irq_cnt + 1'b1;
          end
        end
        ST_GAP: begin
          if (irq_cnt == wake_irq_pkg::CNT_W'(wake_irq_pkg::IRQ_GAP_CYCLES - 1)) begin
            st <= ST_IDLE;
          end else begin
            irq_cnt <= irq_cnt + 1'b1;
          end
        end
        default: begin
          st <= ST_IDLE;
          irq_n_out <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // wake, restart, modulation and bias outputs
  // --------------------------------------------------------------
  // these are requests only; the mode itself is owned elsewhere
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_request <= 1'b0;
      restart_request <= 1'b0;
    end else begin
      wake_request <= pin_wake && wake_en && chip_mode == wake_irq_pkg::MODE_SLEEP;
      restart_request <= filt_edge && chip_mode == wake_irq_pkg::MODE_FAILSAFE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) buck_pwm_select <= 1'b0;
    else if (mod_sel && in_stop && pin_agree) buck_pwm_select <= raw_level;
    else if (!(mod_sel && in_stop)) buck_pwm_select <= 1'b0;
  end

  wake_irq_pkg::bias_drive_t next_bias;
  always_comb begin
    case (bias_sel)
      wake_irq_pkg::BIAS_DOWN: next_bias = '{pull_up: 1'b0, pull_down: 1'b1};
      wake_irq_pkg::BIAS_UP: next_bias = '{pull_up: 1'b1, pull_down: 1'b0};
      wake_irq_pkg::BIAS_AUTO: next_bias = '{pull_up: raw_level, pull_down: !raw_level};
      default: next_bias = '{pull_up: 1'b0, pull_down: 1'b0};
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_up_en <= 1'b0;
      pull_down_en <= 1'b0;
    end else begin
      pull_up_en <= next_bias.pull_up;
      pull_down_en <= next_bias.pull_down;
    end
  end

  // --------------------------------------------------------------
  // read port, data in the cycle after the strobe
  // --------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    case (req.addr)
      wake_irq_pkg::ADDR_CTRL: next_rdata = ctrl;
      wake_irq_pkg::ADDR_BIAS: next_rdata = {6'h00, bias_sel};
      wake_irq_pkg::ADDR_LEVEL: next_rdata = {7'h00, mode_irq && raw_level};
      wake_irq_pkg::ADDR_STAT1: next_rdata = stat1;
      wake_irq_pkg::ADDR_STAT2: next_rdata = stat2;
      wake_irq_pkg::ADDR_SRCEN: next_rdata = src_en;
      default: next_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 8'h00;
    else if (req.rd) rdata <= next_rdata;
    else rdata <= 8'h00;
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_pulse_len;
    @(posedge clk) disable iff (!rst_n)
      $fell(irq_n_out) |-> !irq_n_out [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("irq pulse too short");

  property p_gap;
    @(posedge clk) disable iff (!rst_n)
      $rose(irq_n_out) |-> irq_n_out [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("irq gap too short");

  property p_pulse_end;
    @(posedge clk) disable iff (!rst_n)
      (st == ST_LOW && irq_cnt == wake_irq_pkg::CNT_W'(wake_irq_pkg::IRQ_PULSE_CYCLES - 1))
      |=> irq_n_out && st == ST_GAP;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("irq pulse did not end");

  property p_restart;
    @(posedge clk) disable iff (!rst_n)
      (filt_edge && chip_mode == wake_irq_pkg::MODE_FAILSAFE) |=> restart_request;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart request");

  property p_edge_level;
    @(posedge clk) disable iff (!rst_n)
      filt_edge |-> filt_level != $past(filt_level);
  endproperty
  a_edge_level: assert property (p_edge_level) else $error("edge without level change");

  property p_filter;
    @(posedge clk) disable iff (!rst_n)
      $changed(filt_level) |-> $past(raw_level) == filt_level;
  endproperty
  a_filter: assert property (p_filter) else $error("filter took wrong level");

  property p_flag;
    @(posedge clk) disable iff (!rst_n)
      (irq_fall && pend1[wake_irq_pkg::PIN_WAKE_BIT]) |=> stat1[wake_irq_pkg::PIN_WAKE_BIT];
  endproperty
  a_flag: assert property (p_flag) else $error("pin wake flag missing");

  property p_sleep_wake;
    @(posedge clk) disable iff (!rst_n)
      (pin_wake && wake_en && chip_mode == wake_irq_pkg::MODE_SLEEP) |=> wake_request;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("no wake from sleep");

endmodule

// >>> tb/irq_host_model.sv
// host side model: watches the interrupt line and times its pulses
`timescale 1ns/1ns
module irq_host_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic irq_n_out,
  output int pulse_count,
  output int low_len,
  output int gap_len
);
  int run;
  logic prev;

  // ------------------------------
  // pulse timing
  // ------------------------------
  // the host samples the line on its own clock, so lengths are whole cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev <= 1'b1;
      run <= 0;
      pulse_count <= 0;
      low_len <= 0;
      gap_len <= 0;
    end else begin
      prev <= irq_n_out;
      if (prev !== irq_n_out) begin
        run <= 1;
        if (irq_n_out === 1'b0) begin
          pulse_count <= pulse_count + 1;
          gap_len <= (pulse_count > 0) ? run : 0;
        end else begin
          low_len <= run;
        end
      end else begin
        run <= run + 1;
      end
    end
  end
endmodule

// >>> tb/tb_wake_input_interrupt_signalling.sv
// testbench for the wake input filter and interrupt pulse block
`timescale 1ns/1ns
module tb_wake_input_interrupt_signalling;
  typedef struct packed {
    logic [1:0] code;
    logic pin;
    logic up;
    logic down;
  } row_t;
  localparam int FW = wake_irq_pkg::FILTER_CYCLES + 100;
  localparam int IW = wake_irq_pkg::IRQ_PULSE_CYCLES + 100;
  localparam int GW = wake_irq_pkg::IRQ_GAP_CYCLES + 100;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wake_pin = 1'b0;
  logic [2:0] chip_mode = wake_irq_pkg::MODE_NORMAL;
  logic stop_entry = 1'b0;
  logic cyclic_window = 1'b1;
  logic buck_auto_pwm = 1'b0;
  logic [7:0] other_wake_events = 8'h00;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq_n_out, wake_request, restart_request, buck_pwm_select, pull_up_en, pull_down_en;
  int num_errors = 0;
  int samples_checked = 0;
  int wake_cnt = 0;
  int restart_cnt = 0;
  int pulse_count, low_len, gap_len;
  row_t rows [6] = '{
    '{wake_irq_pkg::BIAS_NONE, 1'b0, 1'b0, 1'b0},
    '{wake_irq_pkg::BIAS_DOWN, 1'b0, 1'b0, 1'b1},
    '{wake_irq_pkg::BIAS_UP, 1'b0, 1'b1, 1'b0},
    '{wake_irq_pkg::BIAS_AUTO, 1'b0, 1'b0, 1'b1},
    '{wake_irq_pkg::BIAS_AUTO, 1'b1, 1'b1, 1'b0},
    '{wake_irq_pkg::BIAS_NONE, 1'b1, 1'b0, 1'b0}};

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (wake_request === 1'b1) wake_cnt++;
    if (restart_request === 1'b1) restart_cnt++;
  end

  wake_irq u_dut (.clk, .resetn, .wake_pin, .chip_mode, .stop_entry, .cyclic_window,
    .buck_auto_pwm, .other_wake_events, .addr, .wdata, .wr, .rd, .rdata, .irq_n_out,
    .wake_request, .restart_request, .buck_pwm_select, .pull_up_en, .pull_down_en);

  irq_host_model u_host (.clk, .resetn, .irq_n_out, .pulse_count, .low_len, .gap_len);

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(32'(rdata), 32'(e));
  endtask

  task automatic wait_irq(input logic lvl, input int lim);
    for (int i = 0; i < lim && irq_n_out !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(irq_n_out), 32'(lvl));
  endtask

  task automatic set_pin(input logic v);
    @(posedge clk);
    wake_pin <= v;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    time t0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(32'({irq_n_out, wake_request, restart_request, buck_pwm_select, pull_up_en,
      pull_down_en, rdata}), 32'h2000);
    for (int a = 0; a < 8; a++) begin
      rd_chk(4'(a), 8'h00);
    end
    wr_reg(4'hF, 8'hFF);
    rd_chk(4'hF, 8'h00);
    // wake disabled: pin moves must not interrupt
    foreach (rows[r]) begin
      set_pin(rows[r].pin);
      wr_reg(wake_irq_pkg::ADDR_BIAS, {6'h00, rows[r].code});
      repeat (10) @(posedge clk);
      #1;
      chk(32'({pull_up_en, pull_down_en}), 32'({rows[r].up, rows[r].down}));
      rd_chk(wake_irq_pkg::ADDR_BIAS, {6'h00, rows[r].code});
      rd_chk(wake_irq_pkg::ADDR_LEVEL, {7'h00, rows[r].pin});
    end
    // the filter must hold the high level before the enabled tests start
    repeat (FW) @(posedge clk);
    chk(32'(pulse_count), 32'h0);
    rd_chk(wake_irq_pkg::ADDR_STAT1, 8'h00);
    wr_reg(wake_irq_pkg::ADDR_CTRL, 8'h01);
    set_pin(1'b0);
    repeat (wake_irq_pkg::FILTER_CYCLES - 600) @(posedge clk);
    set_pin(1'b1);
    repeat (FW) @(posedge clk);
    chk(32'(pulse_count), 32'h0);
    set_pin(1'b0);
    t0 = $time;
    wait_irq(1'b0, FW);
    chk(32'(($time - t0) / 10 >= wake_irq_pkg::FILTER_CYCLES), 32'h1);
    rd_chk(wake_irq_pkg::ADDR_STAT1, 8'h01);
    set_pin(1'b1);
    wait_irq(1'b1, IW);
    repeat (2) @(posedge clk);
    chk(32'(low_len), 32'(wake_irq_pkg::IRQ_PULSE_CYCLES));
    wait_irq(1'b0, GW);
    repeat (2) @(posedge clk);
    chk(32'(gap_len >= wake_irq_pkg::IRQ_GAP_CYCLES), 32'h1);
    wait_irq(1'b1, IW);
    chk(32'(wake_cnt + restart_cnt), 32'h0);
    rd_chk(wake_irq_pkg::ADDR_STAT1, 8'h01);
    @(posedge clk);
    chip_mode <= wake_irq_pkg::MODE_STOP;
    stop_entry <= 1'b1;
    @(posedge clk);
    stop_entry <= 1'b0;
    wait_irq(1'b0, GW);
    wait_irq(1'b1, IW);
    wr_reg(wake_irq_pkg::ADDR_STAT1, 8'h01);
    rd_chk(wake_irq_pkg::ADDR_STAT1, 8'h00);
    // source not enabled in the mask, so this event stays silent
    @(posedge clk);
    other_wake_events <= 8'h01;
    @(posedge clk);
    other_wake_events <= 8'h00;
    wr_reg(wake_irq_pkg::ADDR_CTRL, 8'h04);
    set_pin(1'b1);
    repeat (10) @(posedge clk);
    #1;
    chk(32'(buck_pwm_select), 32'h1);
    set_pin(1'b0);
    repeat (10) @(posedge clk);
    #1;
    chk(32'(buck_pwm_select), 32'h0);
    // let the filter take the low level so that the sleep test sees a real edge
    repeat (FW) @(posedge clk);
    wr_reg(wake_irq_pkg::ADDR_CTRL, 8'h01);
    chip_mode <= wake_irq_pkg::MODE_SLEEP;
    set_pin(1'b1);
    for (int i = 0; i < FW && wake_cnt == 0; i++) @(posedge clk);
    chk(32'(wake_cnt), 32'h1);
    rd_chk(wake_irq_pkg::ADDR_LEVEL, 8'h00);
    wr_reg(wake_irq_pkg::ADDR_CTRL, 8'h00);
    chip_mode <= wake_irq_pkg::MODE_FAILSAFE;
    set_pin(1'b0);
    for (int i = 0; i < FW && restart_cnt == 0; i++) @(posedge clk);
    chk(32'(restart_cnt), 32'h1);
    // cyclic sensing: a closed window holds the filter off
    wr_reg(wake_irq_pkg::ADDR_CTRL, 8'h02);
    cyclic_window <= 1'b0;
    set_pin(1'b1);
    repeat (FW) @(posedge clk);
    chk(32'(restart_cnt), 32'h1);
    cyclic_window <= 1'b1;
    repeat (FW) @(posedge clk);
    chk(32'(restart_cnt), 32'h2);
    repeat (FW) @(posedge clk);
    chk(32'(pulse_count), 32'h3);
    // an enabled source interrupts; a buck change in stop mode waits out the gap
    wr_reg(wake_irq_pkg::ADDR_SRCEN, 8'h02);
    chip_mode <= wake_irq_pkg::MODE_NORMAL;
    @(posedge clk);
    other_wake_events <= 8'h02;
    @(posedge clk);
    other_wake_events <= 8'h00;
    wait_irq(1'b0, GW);
    wait_irq(1'b1, IW);
    @(posedge clk);
    chip_mode <= wake_irq_pkg::MODE_STOP;
    buck_auto_pwm <= 1'b1;
    wait_irq(1'b0, GW);
    // second reset in mid-run, while a pulse is low
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    #1;
    chk(32'(irq_n_out), 32'h1);
    @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(wake_irq_pkg::ADDR_CTRL, wake_irq_pkg::CTRL_RESET);
    rd_chk(wake_irq_pkg::ADDR_SRCEN, wake_irq_pkg::SRCEN_RESET);
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
endmodule
